// File: common/obcrc_regs.svh
// Purpose: constants for the configuration byte decoder
// Assumes: 100 MHz clock, one CPU cycle per clock
// Notes:   bit positions, codes and cycle counts
`ifndef OBCRC_REGS_SVH
`define OBCRC_REGS_SVH
`define OBCRC_BIT_PKG        7
`define OBCRC_BIT_RSTLEN     6
`define OBCRC_SRC_HI         5
`define OBCRC_SRC_LO         4
`define OBCRC_RNG_HI         3
`define OBCRC_RNG_LO         1
`define OBCRC_BIT_DOUBLER_DISABLE     0
`define OBCRC_BYTE_DEFAULT   8'hFF
`define OBCRC_SRC_RESON      2'h0
`define OBCRC_SRC_RSVD       2'h1
`define OBCRC_SRC_RC         2'h2
`define OBCRC_SRC_EXT        2'h3
`define OBCRC_RNG_1_2        3'h0
`define OBCRC_RNG_2_4        3'h1
`define OBCRC_RNG_4_8        3'h2
`define OBCRC_RNG_8_16       3'h3
`define OBCRC_LONG_CYC       13'h1000
`define OBCRC_SHORT_CYC      13'h0100
`define OBCRC_CNT_ZERO       13'h0000
`define OBCRC_CNT_ONE        13'h0001
`endif

// File: common/obcrc_pkg.sv
// Purpose: types for the configuration byte decoder
// Assumes: nothing
// Notes:   state encoding of the stabilisation sequencer
package obcrc_pkg;
    typedef enum logic [1:0] {
        OBCRC_ST_LATCH = 2'b00,
        OBCRC_ST_WAIT  = 2'b01,
        OBCRC_ST_RUN   = 2'b10
    } obcrc_state_e;
    typedef logic [12:0] obcrc_cnt_t;
endpackage

// File: common/obcrc_cnt_if.sv
// Purpose: link between sequencer and stabilisation counter
// Assumes: single clock
// Notes:   load starts a count, done pulses at the end
`timescale 1ns/1ps
interface obcrc_cnt_if;
    import obcrc_pkg::*;
    logic       load;
    obcrc_cnt_t length;
    logic       done;
    modport ctl (output load, output length, input done);
    modport cnt (input load, input length, output done);
endinterface

// File: core/obcrc_stab_counter.sv
// Purpose: counts the stabilisation phase in CPU cycles
// Assumes: one CPU cycle per clock
// Notes:   done pulses exactly length cycles after load
`timescale 1ns/1ps
`include "obcrc_regs.svh"
module obcrc_stab_counter
    import obcrc_pkg::*;
(
    input  wire logic i_clk,         // clock
    input  wire logic i_rstn,        // async reset, active low
    obcrc_cnt_if.cnt  cnt_port       // load and done
);
    obcrc_cnt_t cnt_reg;
    logic       busy_reg;
    logic       done_reg;
    wire        last = busy_reg && (cnt_reg == `OBCRC_CNT_ONE);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg  <= `OBCRC_CNT_ZERO;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (cnt_port.load) begin
            cnt_reg  <= cnt_port.length;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= busy_reg ? cnt_reg - `OBCRC_CNT_ONE : cnt_reg;
            busy_reg <= busy_reg && !last;
            done_reg <= last;
        end
    end
    assign cnt_port.done = done_reg;
endmodule // obcrc_stab_counter

// File: core/obcrc_decoder.sv
// Behaviour
// - reset phase lasts 4096 cycles when bit six is 0, else 256 cycles.
// - leaving halt uses the same stabilisation length as reset.
// - bits 5:4 pick resonator 00, internal rc 10, external 11; 01 reserved.
// - with a resonator, bits 3:1 set the oscillator current range.
// - with an external source, the range is forced to the 2-4 MHz setting.
// - bit zero clear enables the x2 doubler, set bypasses it.
// - bit seven gives the package variant selection.
// - unbonded pads stay input with pull-up after reset.
// - the byte has no bus address; only the programming port reaches it.
//
// Purpose: decodes the second configuration byte into clock settings
// Assumes: byte input is static storage, outside the clock domain
// Notes:   one CPU cycle per clock; outputs are registered
`timescale 1ns/1ps
`include "obcrc_regs.svh"
module obcrc_decoder
    import obcrc_pkg::*;
(
    input  wire logic       i_clk,            // clock, 100 MHz
    input  wire logic       i_rstn,           // async reset, active low
    input  wire logic [7:0] i_config_byte,    // stored configuration byte
    input  wire logic       i_prog_mode,      // programming mode active
    input  wire logic       i_halt_wake,      // halt exit request pulse
    output logic [7:0]      o_prog_rdata,     // byte readback, prog mode only
    output logic [1:0]      o_clock_source_type, // decoded clock source
    output logic            o_source_reserved,   // reserved source code
    output logic [2:0]      o_oscillator_drive_range, // current range
    output logic            o_doubler_enable,  // x2 pll active
    output logic            o_reset_length_select, // 1 = short phase
    output logic            o_package_select_bit,  // package variant
    output logic            o_pad_pullup_keep, // unbonded pads pulled up
    output logic            o_cpu_run,         // stabilisation complete
    output logic            o_stab_active      // stabilisation running
);
    obcrc_state_e state_reg, state_next;
    logic [7:0]   sync1_reg, sync2_reg;
    logic [7:0]   byte_reg;
    logic         wake1_reg, wake2_reg;
    logic         latched_reg;
    obcrc_cnt_if  cnt_bus ();

    function automatic obcrc_cnt_t stab_len(input logic short_sel);
        stab_len = short_sel ? `OBCRC_SHORT_CYC : `OBCRC_LONG_CYC;
    endfunction

    // two-flop capture of static storage, free running through reset
    // so the latch sees the real byte at the first edge after release
    always_ff @(posedge i_clk) begin
        sync1_reg <= i_config_byte;
        sync2_reg <= sync1_reg;
    end

    // two-flop capture of halt wake
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wake1_reg <= 1'b0;
            wake2_reg <= 1'b0;
        end else begin
            wake1_reg <= i_halt_wake;
            wake2_reg <= wake1_reg;
        end
    end

    // decode
    wire [1:0] src_w   = byte_reg[`OBCRC_SRC_HI:`OBCRC_SRC_LO];
    wire       ext_w   = (src_w == `OBCRC_SRC_EXT);
    wire [2:0] rng_w   = ext_w ? `OBCRC_RNG_2_4
                       : byte_reg[`OBCRC_RNG_HI:`OBCRC_RNG_LO];
    wire       dbl_w   = !byte_reg[`OBCRC_BIT_DOUBLER_DISABLE];
    wire       short_w = byte_reg[`OBCRC_BIT_RSTLEN];
    wire       wake_w  = wake2_reg;
    wire       start_w = (state_reg == OBCRC_ST_LATCH)
                      || (state_reg == OBCRC_ST_RUN && wake_w && !o_stab_active);

    assign cnt_bus.load   = start_w && (state_reg != OBCRC_ST_LATCH
                                        || latched_reg);
    assign cnt_bus.length = stab_len(short_w);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            OBCRC_ST_LATCH: if (latched_reg) state_next = OBCRC_ST_WAIT;
            OBCRC_ST_WAIT:  if (cnt_bus.done) state_next = OBCRC_ST_RUN;
            OBCRC_ST_RUN:   if (wake_w) state_next = OBCRC_ST_WAIT;
            default:        state_next = OBCRC_ST_LATCH;
        endcase
    end

    // latch once after reset release, then hold until next reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            byte_reg    <= `OBCRC_BYTE_DEFAULT;
            latched_reg <= 1'b0;
        end else if (!latched_reg) begin
            byte_reg    <= sync2_reg;
            latched_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= OBCRC_ST_LATCH;
            o_stab_active <= 1'b1;
            o_cpu_run <= 1'b0;
        end else begin
            state_reg <= state_next;
            o_stab_active <= (state_next != OBCRC_ST_RUN);
            o_cpu_run <= (state_next == OBCRC_ST_RUN);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_clock_source_type      <= `OBCRC_SRC_RC;
            o_source_reserved        <= 1'b0;
            o_oscillator_drive_range <= `OBCRC_RNG_2_4;
            o_doubler_enable         <= 1'b0;
            o_reset_length_select    <= 1'b0;
            o_package_select_bit     <= 1'b1;
            o_pad_pullup_keep        <= 1'b1;
            o_prog_rdata             <= 8'h00;
        end else begin
            o_clock_source_type      <= src_w;
            o_source_reserved        <= (src_w == `OBCRC_SRC_RSVD);
            o_oscillator_drive_range <= rng_w;
            o_doubler_enable         <= dbl_w;
            o_reset_length_select    <= short_w;
            o_package_select_bit     <= byte_reg[`OBCRC_BIT_PKG];
            o_pad_pullup_keep        <= 1'b1;
            o_prog_rdata <= i_prog_mode ? sync2_reg : 8'h00;
        end
    end

    obcrc_stab_counter u_cnt (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .cnt_port (cnt_bus.cnt)
    );
endmodule // obcrc_decoder

// File: test/obcrc_decoder_properties.sv
// Purpose: port checks of the decoder
// Assumes: one clock, reset async low
// Notes:   bound from the bench
`timescale 1ns/1ps
module obcrc_decoder_properties (
    input wire logic       i_clk,                    // clock
    input wire logic       i_rstn,                   // reset
    input wire logic       i_prog_mode,              // prog mode
    input wire logic       i_halt_wake,              // wake
    input wire logic [7:0] o_prog_rdata,             // readback
    input wire logic [1:0] o_clock_source_type,      // source
    input wire logic       o_source_reserved,        // reserved
    input wire logic [2:0] o_oscillator_drive_range, // range
    input wire logic       o_doubler_enable,         // pll
    input wire logic       o_reset_length_select,    // length
    input wire logic       o_package_select_bit,     // package
    input wire logic       o_pad_pullup_keep,        // pull-up
    input wire logic       o_cpu_run,                // run
    input wire logic       o_stab_active             // stabilising
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [13:0] stab_cnt_reg;
    wire  [13:0] len_w = o_reset_length_select ? 14'h0100 : 14'h1000;
    wire  [13:0] stab_cnt_next = o_stab_active ? stab_cnt_reg + 14'h0001
                                               : 14'h0000;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) stab_cnt_reg <= 14'h0000;
        else stab_cnt_reg <= stab_cnt_next;
    end
    AST_RSVD: assert property (
        o_source_reserved == (o_clock_source_type == 2'h1)) else $error("rsvd");
    AST_EXT_RANGE: assert property (
        o_clock_source_type == 2'h3 |-> o_oscillator_drive_range == 3'h1)
        else $error("ext range");
    AST_PULLUP: assert property (o_pad_pullup_keep) else $error("pullup");
    AST_STATIC: assert property (
        o_cpu_run |-> $stable({o_clock_source_type, o_oscillator_drive_range,
        o_doubler_enable, o_reset_length_select, o_package_select_bit}))
        else $error("settings moved");
    AST_PROG_HIDE: assert property (
        !i_prog_mode [*3] |=> o_prog_rdata == 8'h00) else $error("readback");
    AST_STAB_LEN: assert property (
        $fell(o_stab_active) |-> stab_cnt_reg >= len_w - 14'h0001
        && stab_cnt_reg <= len_w + 14'h0005) else $error("stab length");
    AST_WAKE: assert property (
        o_cpu_run && i_halt_wake |-> ##[1:4] o_stab_active) else $error("wake");
    AST_PAIR: assert property (o_stab_active != o_cpu_run) else $error("pair");
endmodule // obcrc_decoder_properties

// File: test/obcrc_prog_tool.sv
// Purpose: programming tool holding the stored byte
// Assumes: writes while the device is in reset, and once more after the byte is latched
// Notes:   keeps the advised and legal combinations
`timescale 1ns/1ps
module obcrc_prog_tool (
    input  wire logic       i_clk,        // clock
    input  wire logic       i_wr,         // write strobe
    input  wire logic [7:0] i_value,      // requested byte
    output logic      [7:0] o_config_byte // stored byte
);
    function automatic logic [7:0] legal(input logic [7:0] v);
        legal = v;
        if (v[5:4] == 2'h0) legal[6] = 1'b0;
        if (v[5:4] == 2'h2 || v[3:1] != 3'h1) legal[0] = 1'b1;
    endfunction
    initial o_config_byte = 8'hFF;
    always @(posedge i_clk) if (i_wr) o_config_byte <= legal(i_value);
endmodule // obcrc_prog_tool

// File: test/obcrc_decoder_bench.sv
// Purpose: self-checking bench of the decoder
// Assumes: 100 MHz clock
// Notes:   corner bytes then random ones
`timescale 1ns/1ps
module obcrc_decoder_bench;
    logic i_clk, i_rstn, i_prog_mode, i_halt_wake, wr;
    logic [7:0] val, lb;
    logic [7:0] cases [5] = '{8'h02, 8'hC6, 8'hE1, 8'h78, 8'h54};
    wire logic [7:0] cfg, o_prog_rdata;
    wire logic [1:0] o_clock_source_type;
    wire logic [2:0] o_oscillator_drive_range;
    wire logic o_source_reserved, o_doubler_enable, o_reset_length_select;
    wire logic o_package_select_bit, o_pad_pullup_keep, o_cpu_run, o_stab_active;
    wire logic [15:0] dec_w = {6'h00, o_clock_source_type, o_source_reserved,
        o_oscillator_drive_range, o_doubler_enable, o_reset_length_select,
        o_package_select_bit, o_pad_pullup_keep};
    int n_errors = 0, compares = 0, cyc = 0, n, len;
    obcrc_prog_tool i_obcrc_prog_tool (.i_clk(i_clk), .i_wr(wr),
        .i_value(val), .o_config_byte(cfg));
    obcrc_decoder i_obcrc_decoder (.i_clk, .i_rstn, .i_config_byte(cfg),
        .i_prog_mode, .i_halt_wake, .o_prog_rdata, .o_clock_source_type,
        .o_source_reserved, .o_oscillator_drive_range, .o_doubler_enable,
        .o_reset_length_select, .o_package_select_bit, .o_pad_pullup_keep,
        .o_cpu_run, .o_stab_active);
    function automatic logic [15:0] exp_dec(input logic [7:0] b);
        exp_dec = {6'h00, b[5:4], b[5:4] == 2'h1,
            b[5:4] == 2'h3 ? 3'h1 : b[3:1], ~b[0], b[6], b[7], 1'b1};
    endfunction
    task automatic chk(input string what, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_run;
        for (n = 0; n < 5000 && o_cpu_run !== 1'b1; n++) @(posedge i_clk);
    endtask
    task automatic run_case(input logic [7:0] b);
        i_rstn <= 1'b0;
        wr <= 1'b1;
        val <= b;
        @(posedge i_clk) wr <= 1'b0;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        i_prog_mode <= 1'b1;
        lb = cfg;
        len = lb[6] ? 256 : 4096;
        repeat (6) @(posedge i_clk);
        chk("rdata", {8'h00, lb}, o_prog_rdata);
        i_prog_mode <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk("rdata_off", 0, o_prog_rdata);
        chk("decode", exp_dec(lb), dec_w);
        wr <= 1'b1;
        val <= ~b;
        @(posedge i_clk) wr <= 1'b0;
        wait_run;
        chk("run_delay", 1, n + 11 >= len && n + 11 <= len + 6);
        chk("static", exp_dec(lb), dec_w);
        i_halt_wake <= 1'b1;
        @(posedge i_clk) i_halt_wake <= 1'b0;
        repeat (5) @(posedge i_clk);
        wait_run;
        chk("wake_delay", 1, n + 6 >= len && n + 6 <= len + 8);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 100000) begin
            n_errors++;
            summarize;
        end
    end
    initial begin
        {i_rstn, i_prog_mode, i_halt_wake, wr} = 4'h0;
        val = 8'hFF;
        void'($urandom(72));
        repeat (16) @(posedge i_clk);
        for (int k = 0; k < 8; k++) run_case(k < 5 ? cases[k] : 8'($urandom));
        summarize;
    end
endmodule // obcrc_decoder_bench
bind obcrc_decoder obcrc_decoder_properties i_obcrc_decoder_properties (.*);
